// ### hw/ewm_fifo.sv
// small transmit fifo with registered ready
`timescale 1ns/1ps
module ewm_fifo #(parameter int WIDTH = 9, parameter int DEPTH = 4) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   ewm_stream_if.sink s_in,
   ewm_stream_if.source s_out
);
   localparam int PW = $clog2(DEPTH);
   // pointers wrap naturally, so depth must be a power of two
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wptr;
      logic [PW-1:0] rptr;
      logic [PW:0] count;
      logic ready;
   } ewm_fifo_t;
   ewm_fifo_t f_reg, f_next;
   logic do_push;
   logic do_pop;

   always_comb begin
      f_next = f_reg;
      do_push = s_in.valid && f_reg.ready;
      do_pop = s_out.ready && (f_reg.count != '0);
      if (do_push) begin
         f_next.mem[f_reg.wptr] = s_in.data;
         f_next.wptr = f_reg.wptr + 1'b1;
      end
      if (do_pop) begin
         f_next.rptr = f_reg.rptr + 1'b1;
      end
      case ({do_push, do_pop})
         2'b10: f_next.count = f_reg.count + 1'b1;
         2'b01: f_next.count = f_reg.count - 1'b1;
         default: f_next.count = f_reg.count;
      endcase
      f_next.ready = (f_next.count < DEPTH);
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         f_reg <= '{mem: '0, wptr: '0, rptr: '0, count: '0, ready: 1'b1};
      end else begin
         f_reg <= f_next;
      end
   end

   assign s_in.ready = f_reg.ready;
   assign s_out.valid = (f_reg.count != '0);
   assign s_out.data = f_reg.mem[f_reg.rptr];
endmodule : ewm_fifo

// ### hw/ewm_master.sv
// byte-level two-wire bus master for a serial eeprom
// Function
// - loading a byte into the transmit data register launches a transfer
// - a transfer begins with a start condition, then the target address byte
// - loading the transmit data register clears transmit_empty, meaning busy
// - after the byte is shifted out, transmit_empty sets if no byte is queued, and an event pulses
// - reads: address with direction 1, then a dummy byte; this clears receive_full
// - a received byte sets receive_full and pulses an event
// - reading the receive data register clears receive_full
// - stop_after_read at 1 gives a stop after the received byte
// - stop_after_read at 0 keeps the read open for more bytes
// - stop_after_write at 1 gives a stop after the transmitted byte
// - stop_after_write at 0 leaves the transfer open for the next byte
// - address bit zero picks direction: 0 write, 1 read
// - speed select: clear gives 100 kHz, set gives 400 kHz
// - no answer from target sets bus error; writing 1 clears it
`timescale 1ns/1ps
module ewm_master
   import ewm_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_addr_write,
   input wire logic [7:0] i_addr_data,
   input wire logic i_tx_write,
   input wire logic [7:0] i_tx_data,
   output logic o_tx_ready,
   input wire logic i_rx_read,
   output logic [7:0] o_receive_data,
   input wire logic i_stop_after_write,
   input wire logic i_stop_after_read,
   input wire logic i_speed_fast,
   input wire logic i_status_write,
   input wire logic i_status_err_wdata,
   output logic o_transmit_empty,
   output logic o_receive_full,
   output logic o_bus_error,
   output logic o_tx_event,
   output logic o_rx_event,
   output logic o_busy,
   input wire logic i_scl,
   output logic o_scl_out,
   output logic o_scl_oe_n,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe_n
);
   ewm_ctl_t r_reg, r_next;
   logic scl_s;
   logic sda_s;
   logic stretch;
   logic tick;
   logic ack_end;
   logic pop;
   logic err_set;

   ewm_stream_if #(.WIDTH(TX_WIDTH)) push_if ();
   ewm_stream_if #(.WIDTH(TX_WIDTH)) pop_if ();

   ewm_sync2 #(.WIDTH(2)) u_sync (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_async({i_scl, i_sda}),
      .o_sync({scl_s, sda_s})
   );

   // the processor may queue bytes ahead; full fifo refuses writes via o_tx_ready
   ewm_fifo #(.WIDTH(TX_WIDTH), .DEPTH(TX_DEPTH)) u_fifo (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .s_in(push_if.sink),
      .s_out(pop_if.source)
   );

   assign push_if.valid = i_tx_write;
   assign push_if.data = {i_stop_after_write, i_tx_data};
   assign pop_if.ready = pop;

   function automatic logic [7:0] quarter_max(input logic fast);
      return fast ? QTR_FAST_MAX : QTR_SLOW_MAX;
   endfunction : quarter_max

   function automatic logic is_rx(input ewm_kind_t kind);
      return kind == K_RD;
   endfunction : is_rx

   // a target holding scl low freezes the quarter count
   assign stretch = r_reg.scl_oe_n && !scl_s;
   assign tick = (r_reg.cnt == 8'h00) && !stretch;
   assign ack_end = (r_reg.state == ST_BYTE) && (r_reg.bitn == ACK_BIT) &&
      (r_reg.qtr == QTR_LAST) && tick;

   always_comb begin
      r_next = r_reg;
      r_next.tx_ev = 1'b0;
      r_next.rx_ev = 1'b0;
      pop = 1'b0;
      err_set = 1'b0;
      if (i_addr_write) begin
         r_next.tar = i_addr_data;
      end
      if (tick) begin
         r_next.cnt = quarter_max(i_speed_fast);
         r_next.qtr = r_reg.qtr + 2'h1;
      end else if (!stretch) begin
         r_next.cnt = r_reg.cnt - 8'h01;
      end
      case (r_reg.state)
         ST_IDLE: begin
            r_next.qtr = 2'h0;
            if (pop_if.valid) begin
               r_next.state = ST_START;
               r_next.cnt = quarter_max(i_speed_fast);
               r_next.kind = K_ADDR;
               r_next.shreg = r_reg.tar;
               r_next.bitn = 4'h0;
               r_next.busy = 1'b1;
               r_next.rd_dir = r_reg.tar[DIR_BIT];
               if (r_reg.tar[DIR_BIT]) begin
                  pop = 1'b1; // dummy byte only starts the read
                  r_next.receive_full = 1'b0;
               end
            end
         end
         ST_START: begin
            if (tick) begin
               case (r_reg.qtr)
                  2'h1: r_next.sda_oe_n = 1'b0;
                  2'h2: r_next.scl_oe_n = 1'b0;
                  2'h3: r_next.state = ST_BYTE;
                  default: r_next.sda_oe_n = 1'b1;
               endcase
            end
         end
         ST_BYTE: begin
            if (tick) begin
               case (r_reg.qtr)
                  2'h0: begin
                     if (r_reg.bitn == ACK_BIT) begin
                        r_next.sda_oe_n = is_rx(r_reg.kind) ? r_reg.last : 1'b1;
                     end else begin
                        r_next.sda_oe_n = is_rx(r_reg.kind) ? 1'b1 : r_reg.shreg[7];
                     end
                  end
                  2'h1: r_next.scl_oe_n = 1'b1;
                  2'h2: begin
                     if (r_reg.bitn == ACK_BIT) begin
                        r_next.ackbit = sda_s;
                     end else if (is_rx(r_reg.kind)) begin
                        r_next.shreg = {r_reg.shreg[6:0], sda_s};
                     end
                  end
                  default: begin
                     r_next.scl_oe_n = 1'b0;
                     if (r_reg.bitn != ACK_BIT) begin
                        r_next.bitn = r_reg.bitn + 4'h1;
                        if (!is_rx(r_reg.kind)) begin
                           r_next.shreg = {r_reg.shreg[6:0], 1'b0};
                        end else if (r_reg.bitn == LAST_DATA_BIT) begin
                           r_next.rxdata = r_reg.shreg;
                           r_next.receive_full = 1'b1;
                           r_next.rx_ev = 1'b1;
                           r_next.last = i_stop_after_read;
                        end
                     end else begin
                        r_next.bitn = 4'h0;
                        case (r_reg.kind)
                           K_ADDR: begin
                              if (r_reg.ackbit) begin
                                 err_set = 1'b1;
                                 r_next.state = ST_STOP;
                                 if (!r_reg.rd_dir) begin
                                    pop = 1'b1; // drop the byte so a dead target cannot hang us
                                    r_next.tx_ev = 1'b1;
                                 end
                              end else if (r_reg.rd_dir) begin
                                 r_next.kind = K_RD;
                                 r_next.transmit_empty = !pop_if.valid;
                              end else begin
                                 r_next.kind = K_WR;
                                 pop = 1'b1;
                                 r_next.shreg = pop_if.data[7:0];
                                 r_next.stop_after_write = pop_if.data[SWR_BIT];
                              end
                           end
                           K_WR: begin
                              r_next.tx_ev = 1'b1;
                              r_next.transmit_empty = !pop_if.valid;
                              if (r_reg.ackbit) begin
                                 err_set = 1'b1;
                                 r_next.state = ST_STOP;
                              end else begin
                                 r_next.state = r_reg.stop_after_write ? ST_STOP : ST_HOLD;
                              end
                           end
                           default: begin
                              r_next.state = r_reg.last ? ST_STOP : ST_HOLD;
                           end
                        endcase
                     end
                  end
               endcase
            end
         end
         ST_HOLD: begin
            r_next.qtr = 2'h0;
            r_next.cnt = quarter_max(i_speed_fast);
            if (r_reg.rd_dir) begin
               if (!r_reg.receive_full) begin
                  r_next.state = ST_BYTE;
               end
            end else if (pop_if.valid) begin
               pop = 1'b1;
               r_next.shreg = pop_if.data[7:0];
               r_next.stop_after_write = pop_if.data[SWR_BIT];
               r_next.state = ST_BYTE;
            end
         end
         ST_STOP: begin
            if (tick) begin
               case (r_reg.qtr)
                  2'h0: r_next.sda_oe_n = 1'b0;
                  2'h1: r_next.scl_oe_n = 1'b1;
                  2'h2: r_next.sda_oe_n = 1'b1;
                  default: begin
                     r_next.state = ST_IDLE;
                     r_next.busy = 1'b0;
                     r_next.transmit_empty = r_reg.transmit_empty || !pop_if.valid;
                  end
               endcase
            end
         end
         default: r_next.state = ST_IDLE;
      endcase
      if (err_set) begin
         r_next.err = 1'b1;
      end else if (i_status_write && i_status_err_wdata) begin
         r_next.err = 1'b0;
      end
      // a new byte arriving as the old one finishes keeps the block busy
      if (i_tx_write && push_if.ready) begin
         r_next.transmit_empty = 1'b0;
      end
      if (i_rx_read && !r_next.rx_ev) begin
         r_next.receive_full = 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r_reg <= CTL_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   assign o_tx_ready = push_if.ready;
   assign o_receive_data = r_reg.rxdata;
   assign o_transmit_empty = r_reg.transmit_empty;
   assign o_receive_full = r_reg.receive_full;
   assign o_bus_error = r_reg.err;
   assign o_tx_event = r_reg.tx_ev;
   assign o_rx_event = r_reg.rx_ev;
   assign o_busy = r_reg.busy;
   // open drain: only ever pull low
   assign o_scl_out = 1'b0;
   assign o_sda_out = 1'b0;
   assign o_scl_oe_n = r_reg.scl_oe_n;
   assign o_sda_oe_n = r_reg.sda_oe_n;

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);

   property p_start_on_load;
      (r_reg.state == ST_IDLE && pop_if.valid) |=> (r_reg.state == ST_START && r_reg.busy);
   endproperty
   a_start_on_load: assert property (p_start_on_load) else $error("no start");
   property p_start_cond;
      (r_reg.state == ST_START && $fell(r_reg.sda_oe_n)) |-> r_reg.scl_oe_n;
   endproperty
   a_start_cond: assert property (p_start_cond) else $error("bad start");
   property p_push_clears_txe;
      (i_tx_write && push_if.ready) |=> !r_reg.transmit_empty;
   endproperty
   a_push_clears_txe: assert property (p_push_clears_txe) else $error("txe kept");
   property p_txe_set;
      (ack_end && r_reg.kind == K_WR && !pop_if.valid && !i_tx_write) |=>
         (r_reg.transmit_empty && r_reg.tx_ev);
   endproperty
   a_txe_set: assert property (p_txe_set) else $error("txe not set");
   property p_rd_clears_rxf;
      (r_reg.state == ST_IDLE && pop_if.valid && r_reg.tar[DIR_BIT]) |=> !r_reg.receive_full;
   endproperty
   a_rd_clears_rxf: assert property (p_rd_clears_rxf) else $error("rxf kept");
   property p_rx_latch;
      $rose(r_reg.receive_full) |-> (r_reg.rx_ev && r_reg.rxdata == $past(r_reg.shreg));
   endproperty
   a_rx_latch: assert property (p_rx_latch) else $error("bad latch");
   property p_rx_read;
      (i_rx_read && !r_next.rx_ev) |=> !r_reg.receive_full;
   endproperty
   a_rx_read: assert property (p_rx_read) else $error("rxf not cleared");
   property p_stop_rd;
      (ack_end && r_reg.kind == K_RD && r_reg.last) |=> r_reg.state == ST_STOP ##1
         r_reg.state == ST_STOP;
   endproperty
   a_stop_rd: assert property (p_stop_rd) else $error("no read stop");
   property p_hold_rd;
      (ack_end && r_reg.kind == K_RD && !r_reg.last) |=> r_reg.state == ST_HOLD;
   endproperty
   a_hold_rd: assert property (p_hold_rd) else $error("read closed");
   property p_wr_end;
      (ack_end && r_reg.kind == K_WR && !r_reg.ackbit) |=>
         r_reg.state == ($past(r_reg.stop_after_write) ? ST_STOP : ST_HOLD);
   endproperty
   a_wr_end: assert property (p_wr_end) else $error("bad write end");
   property p_dir;
      (ack_end && r_reg.kind == K_ADDR && !r_reg.ackbit) |=>
         r_reg.kind == ($past(r_reg.rd_dir) ? K_RD : K_WR);
   endproperty
   a_dir: assert property (p_dir) else $error("bad direction");
   property p_err;
      (r_reg.err && !(i_status_write && i_status_err_wdata)) |=> r_reg.err;
   endproperty
   a_err: assert property (p_err) else $error("error lost");
   property p_nack_last;
      (r_reg.state == ST_BYTE && is_rx(r_reg.kind) && r_reg.bitn == ACK_BIT &&
         r_reg.qtr == 2'h2) |-> r_reg.sda_oe_n == r_reg.last;
   endproperty
   a_nack_last: assert property (p_nack_last) else $error("bad read ack");
endmodule : ewm_master

// ### hw/ewm_pkg.sv
// shared constants, states and control record of the two-wire eeprom master
package ewm_pkg;
   localparam int CLK_HZ = 40000000;
   localparam int BUS_SLOW_HZ = 100000;
   localparam int BUS_FAST_HZ = 400000;
   // one bit time is four quarters; the division floors, so a quarter is never longer than nominal
   localparam int QTR_SLOW_INT = CLK_HZ / (4 * BUS_SLOW_HZ);
   localparam int QTR_FAST_INT = CLK_HZ / (4 * BUS_FAST_HZ);
   localparam logic [7:0] QTR_SLOW_MAX = 8'(QTR_SLOW_INT - 1);
   localparam logic [7:0] QTR_FAST_MAX = 8'(QTR_FAST_INT - 1);
   localparam int DIR_BIT = 0;
   localparam int SWR_BIT = 8;
   localparam int TX_WIDTH = 9;
   localparam int TX_DEPTH = 4;
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [3:0] ACK_BIT = 4'h8;
   localparam logic [1:0] QTR_LAST = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_START = 3'b001,
      ST_BYTE = 3'b010,
      ST_HOLD = 3'b011,
      ST_STOP = 3'b100
   } ewm_state_t;

   typedef enum logic [1:0] {
      K_ADDR = 2'b00,
      K_WR = 2'b01,
      K_RD = 2'b10
   } ewm_kind_t;

   typedef struct packed {
      ewm_state_t state;
      ewm_kind_t kind;
      logic [1:0] qtr;
      logic [7:0] cnt;
      logic [3:0] bitn;
      logic [7:0] shreg;
      logic [7:0] tar;
      logic [7:0] rxdata;
      logic rd_dir;
      logic last;
      logic stop_after_write;
      logic ackbit;
      logic receive_full;
      logic transmit_empty;
      logic err;
      logic tx_ev;
      logic rx_ev;
      logic busy;
      logic scl_oe_n;
      logic sda_oe_n;
   } ewm_ctl_t;

   localparam ewm_ctl_t CTL_RESET = '{state: ST_IDLE, kind: K_ADDR, qtr: 2'h0, cnt: 8'h00,
      bitn: 4'h0, shreg: 8'h00, tar: 8'h00, rxdata: 8'h00, rd_dir: 1'b0, last: 1'b0,
      stop_after_write: 1'b0, ackbit: 1'b0, receive_full: 1'b0, transmit_empty: 1'b1, err: 1'b0, tx_ev: 1'b0, rx_ev: 1'b0,
      busy: 1'b0, scl_oe_n: 1'b1, sda_oe_n: 1'b1};
endpackage : ewm_pkg

// ### hw/ewm_stream_if.sv
// valid/ready byte stream between the master and its transmit fifo
`timescale 1ns/1ps
interface ewm_stream_if #(parameter int WIDTH = 9) ();
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport source (output valid, output data, input ready);
   modport sink (input valid, input data, output ready);
endinterface : ewm_stream_if

// ### hw/ewm_sync2.sv
// two-flop synchroniser for the bus pins
`timescale 1ns/1ps
module ewm_sync2 #(parameter int WIDTH = 2) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } ewm_sync_t;
   ewm_sync_t s_reg, s_next;

   // idle bus lines are high, so reset to high avoids a false start
   always_comb begin
      s_next.meta = i_async;
      s_next.sync = s_reg.meta;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_reg <= '1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_sync = s_reg.sync;
endmodule : ewm_sync2

// ### tb/ewm_eeprom_model.sv
// behavioural serial eeprom target with an auto-incrementing byte pointer
`timescale 1ns/1ps
module ewm_eeprom_model #(parameter logic [6:0] DEV_ADDR = 7'h50) (
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_low
);
   logic [7:0] mem [256];
   logic [7:0] sh = 8'h00;
   logic [7:0] ptr = 8'h00;
   logic act = 1'b0;
   logic send = 1'b0;
   logic mack = 1'b1;
   int bitn = 0;
   int nbyte = 0;
   int n_stop = 0;
   int n_ack = 0;
   int n_nack = 0;
   initial begin
      o_sda_low = 1'b0;
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i) ^ 8'h5a;
      end
   end
   // start: data falls while the clock is high
   always @(negedge i_sda) begin
      if (i_scl === 1'b1) begin
         act = 1'b1;
         send = 1'b0;
         bitn = -1;
         nbyte = 0;
      end
   end
   always @(posedge i_sda) begin
      if (i_scl === 1'b1) n_stop++;
   end
   always @(posedge i_scl) begin
      if (act && !send && bitn < 8) sh = {sh[6:0], i_sda};
      if (act && send && bitn == 8) begin
         mack = i_sda;
         if (mack) n_nack++;
         else n_ack++;
      end
   end
   // the line changes right at the clock fall, no kinder hold than a real part
   always @(negedge i_scl) begin
      if (act) begin
         bitn++;
         if (bitn == 9) begin
            bitn = 0;
            if (!send) begin
               if (nbyte == 0) begin
                  send = sh[0];
                  act = (sh[7:1] == DEV_ADDR);
               end else if (nbyte == 2) begin
                  ptr = sh;
               end else if (nbyte > 2) begin
                  mem[ptr] = sh;
                  ptr++;
               end
               nbyte++;
            end else if (mack) begin
               send = 1'b0;
            end
         end
         if (send && act) o_sda_low = (bitn < 8) ? ~mem[ptr][3'(7 - bitn)] : 1'b0;
         else o_sda_low = act && (bitn == 8) && (nbyte > 0 || sh[7:1] == DEV_ADDR);
         if (send && act && bitn == 8) ptr++;
      end
   end
endmodule : ewm_eeprom_model

// ### tb/tb_two_wire_eeprom_master.sv
// self-checking bench for the two-wire eeprom master against a behavioural target
`timescale 1ns/1ps
module tb_two_wire_eeprom_master
   import ewm_pkg::*;
;
   localparam logic [6:0] DEV = 7'h50;
   logic i_sys_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_addr_write = 1'b0;
   logic [7:0] i_addr_data = 8'h00;
   logic i_tx_write = 1'b0;
   logic [7:0] i_tx_data = 8'h00;
   logic i_rx_read = 1'b0;
   logic i_stop_after_write = 1'b0;
   logic i_stop_after_read = 1'b0;
   logic i_speed_fast = 1'b1;
   logic i_status_write = 1'b0;
   logic i_status_err_wdata = 1'b0;
   logic o_tx_ready, o_transmit_empty, o_receive_full, o_bus_error, o_tx_event, o_rx_event;
   logic o_busy, o_scl_out, o_scl_oe_n, o_sda_out, o_sda_oe_n, sda_low, full_seen;
   logic [7:0] o_receive_data;
   int n_mismatch = 0;
   int checks_done = 0;
   int s0, a0, k0, n;
   // open-drain lines with pull-ups
   wire scl_line = o_scl_oe_n ? 1'b1 : o_scl_out;
   wire sda_line = (o_sda_oe_n ? 1'b1 : o_sda_out) & ~sda_low;

   always #12.5 i_sys_clk = ~i_sys_clk;

   ewm_master dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr_write(i_addr_write),
      .i_addr_data(i_addr_data), .i_tx_write(i_tx_write), .i_tx_data(i_tx_data),
      .o_tx_ready(o_tx_ready), .i_rx_read(i_rx_read), .o_receive_data(o_receive_data),
      .i_stop_after_write(i_stop_after_write), .i_stop_after_read(i_stop_after_read),
      .i_speed_fast(i_speed_fast), .i_status_write(i_status_write),
      .i_status_err_wdata(i_status_err_wdata), .o_transmit_empty(o_transmit_empty),
      .o_receive_full(o_receive_full), .o_bus_error(o_bus_error), .o_tx_event(o_tx_event),
      .o_rx_event(o_rx_event), .o_busy(o_busy), .i_scl(scl_line), .o_scl_out(o_scl_out),
      .o_scl_oe_n(o_scl_oe_n), .i_sda(sda_line), .o_sda_out(o_sda_out),
      .o_sda_oe_n(o_sda_oe_n));
   ewm_eeprom_model #(.DEV_ADDR(DEV)) model (.i_scl(scl_line), .i_sda(sda_line),
      .o_sda_low(sda_low));

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic finish_test();
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : finish_test

   function automatic logic pick(input int sel);
      case (sel)
         0: return o_busy;
         1: return o_tx_event;
         default: return o_rx_event;
      endcase
   endfunction : pick

   task automatic wait_for(input int sel, input logic lvl);
      int k;
      k = 0;
      do begin
         @(posedge i_sys_clk);
         #1;
         k++;
      end while (pick(sel) !== lvl && k < 20000);
      // a level that never comes is a failure, not a silent return
      if (pick(sel) !== lvl) n_mismatch++;
   endtask : wait_for

   task automatic wait_idle();
      repeat (3) @(posedge i_sys_clk);
      wait_for(0, 1'b0);
   endtask : wait_idle

   task automatic set_addr(input logic [7:0] a, input logic stop_after_read);
      @(posedge i_sys_clk);
      i_addr_write <= 1'b1;
      i_addr_data <= a;
      i_stop_after_read <= stop_after_read;
      @(posedge i_sys_clk);
      i_addr_write <= 1'b0;
   endtask : set_addr

   // a full fifo holds the push back until room appears
   task automatic push(input logic [7:0] d, input logic stop);
      int k;
      k = 0;
      @(posedge i_sys_clk);
      #1;
      while (o_tx_ready !== 1'b1 && k < 20000) begin
         full_seen = 1'b1;
         @(posedge i_sys_clk);
         #1;
         k++;
      end
      if (o_tx_ready !== 1'b1) n_mismatch++;
      @(posedge i_sys_clk);
      i_tx_write <= 1'b1;
      i_tx_data <= d;
      i_stop_after_write <= stop;
      @(posedge i_sys_clk);
      i_tx_write <= 1'b0;
   endtask : push

   task automatic pulse_side(input logic rd, input logic d);
      @(posedge i_sys_clk);
      i_rx_read <= rd;
      i_status_write <= !rd;
      i_status_err_wdata <= d;
      @(posedge i_sys_clk);
      i_rx_read <= 1'b0;
      i_status_write <= 1'b0;
      @(posedge i_sys_clk);
      #1;
   endtask : pulse_side

   // clock-fall to clock-fall span, one bit time; the first fall ends the start and the second ends bit one, so skip both
   task automatic measure(output int cnt);
      logic hi;
      hi = 1'b0;
      repeat (2) @(negedge scl_line);
      cnt = 0;
      while (!(hi && scl_line === 1'b0)) begin
         @(posedge i_sys_clk);
         cnt++;
         if (scl_line === 1'b1) hi = 1'b1;
      end
   endtask : measure

   initial begin
      #2000000;
      n_mismatch++;
      finish_test();
   end

   initial begin
      repeat (3) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      @(posedge i_sys_clk);
      #1;
      check("reset flags", 8'({o_transmit_empty, o_receive_full, o_bus_error, o_busy}), 8'h08);
      check("reset lines", 8'({o_scl_oe_n, o_sda_oe_n, o_tx_ready}), 8'h07);
      s0 = model.n_stop;
      set_addr({DEV, 1'b0}, 1'b0);
      push(8'h00, 1'b0);
      repeat (2) @(posedge i_sys_clk);
      #1;
      check("transmit_empty", 8'(o_transmit_empty), 8'h00);
      measure(n);
      check("fast bit time", 8'(n >= 4 * QTR_FAST_INT && n <= 4 * QTR_FAST_INT + 4), 8'h01);
      wait_for(1, 1'b1);
      check("transmit_empty", 8'(o_transmit_empty), 8'h01);
      push(8'h10, 1'b0);
      wait_for(1, 1'b1);
      check("open write", 8'({o_busy, model.n_stop == s0}), 8'h03);
      push(8'hc3, 1'b1);
      wait_idle();
      check("write stop", 8'(model.n_stop - s0), 8'h01);
      check("byte write", model.mem[8'h10], 8'hc3);
      s0 = model.n_stop;
      full_seen = 1'b0;
      set_addr({DEV, 1'b0}, 1'b0);
      push(8'h00, 1'b0);
      push(8'h20, 1'b0);
      for (int i = 0; i < 4; i++) begin
         push(8'h80 + 8'(i), i == 3);
      end
      wait_idle();
      for (int i = 0; i < 4; i++) begin
         check("page byte", model.mem[8'h20 + 8'(i)], 8'h80 + 8'(i));
      end
      check("page stop", 8'(model.n_stop - s0), 8'h01);
      check("fifo refused", 8'(full_seen), 8'h01);
      s0 = model.n_stop;
      a0 = model.n_ack;
      k0 = model.n_nack;
      set_addr({DEV, 1'b1}, 1'b1);
      push(8'hff, 1'b0);
      wait_for(2, 1'b1);
      check("single read", o_receive_data, 8'h24 ^ 8'h5a);
      check("receive_full", 8'(o_receive_full), 8'h01);
      wait_idle();
      check("read stop", 8'(model.n_stop - s0), 8'h01);
      check("read acks", 8'({4'(model.n_ack - a0), 4'(model.n_nack - k0)}), 8'h01);
      s0 = model.n_stop;
      a0 = model.n_ack;
      k0 = model.n_nack;
      set_addr({DEV, 1'b1}, 1'b0);
      push(8'hff, 1'b0);
      wait_for(0, 1'b1);
      repeat (40) @(posedge i_sys_clk);
      #1;
      check("receive_full", 8'(o_receive_full), 8'h00);
      for (int i = 0; i < 3; i++) begin
         wait_for(2, 1'b1);
         check("seq read", o_receive_data, (8'h25 + 8'(i)) ^ 8'h5a);
         if (i < 2) check("open read", 8'(model.n_stop - s0), 8'h00);
         if (i == 1) begin
            @(posedge i_sys_clk);
            i_stop_after_read <= 1'b1;
         end
         pulse_side(1'b1, 1'b0);
         check("receive_full", 8'(o_receive_full), 8'h00);
      end
      wait_idle();
      check("seq stop", 8'(model.n_stop - s0), 8'h01);
      check("seq acks", 8'({4'(model.n_ack - a0), 4'(model.n_nack - k0)}), 8'h21);
      set_addr({7'h21, 1'b0}, 1'b0);
      i_speed_fast <= 1'b0;
      push(8'h55, 1'b1);
      measure(n);
      check("slow bit time", 8'(n >= 4 * QTR_SLOW_INT && n <= 4 * QTR_SLOW_INT + 4), 8'h01);
      wait_idle();
      check("bus_error", 8'(o_bus_error), 8'h01);
      pulse_side(1'b0, 1'b0);
      check("bus_error", 8'(o_bus_error), 8'h01);
      pulse_side(1'b0, 1'b1);
      check("bus_error", 8'(o_bus_error), 8'h00);
      finish_test();
   end
endmodule : tb_two_wire_eeprom_master
